// *** logic/cbac_pkg.sv ***
package cbac_pkg;

  // ********************************************************************
  // Widths and register map
  // ********************************************************************
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned THR_W  = 14;
  localparam int unsigned EXP_W  = 10;
  localparam int unsigned CELL_N = 14;
  localparam int unsigned IDX_W  = 4;

  localparam logic [7:0] OFS_EXPIRY = 8'h7d;
  localparam logic [7:0] OFS_THR    = 8'h7e;
  localparam logic [7:0] OFS_TIMING = 8'h7f;

  // ********************************************************************
  // Field positions and reset values
  // ********************************************************************
  localparam int unsigned EXP_LSB  = 0;
  localparam int unsigned THR_LSB  = 2;
  localparam int unsigned SEL_BIT  = 0;
  localparam int unsigned NTFY_LSB = 8;
  localparam int unsigned CAL_LSB  = 0;

  localparam logic [EXP_W-1:0] EXP_RESET    = 10'h000;
  localparam logic [EXP_W-1:0] EXP_FOREVER  = 10'h3ff;
  localparam logic [THR_W-1:0] THR_ALL_ONES = 14'h3fff;
  localparam logic [1:0]       NTFY_RESET   = 2'h0;
  localparam logic [2:0]       CAL_RESET    = 3'h0;

  // ********************************************************************
  // Modes and time units
  // ********************************************************************
  typedef enum logic [2:0] {
    MODE_OFF     = 3'h0, MODE_EMERG    = 3'h1,
    MODE_MAN_SEC = 3'h2, MODE_MAN_MIN  = 3'h3,
    MODE_IND_SEC = 3'h4, MODE_IND_MIN  = 3'h5,
    MODE_GRP_SEC = 3'h6, MODE_GRP_MIN  = 3'h7
  } cbac_mode_t;

  localparam logic [1:0] UNIT_NONE = 2'h0;
  localparam logic [1:0] UNIT_SEC  = 2'h1;
  localparam logic [1:0] UNIT_MIN  = 2'h2;
  localparam logic [1:0] UNIT_HOUR = 2'h3;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam longint unsigned CLK_PERIOD_NS = 100;
  localparam longint unsigned SECOND_NS     = 1_000_000_000;
  localparam int unsigned     SECOND_CYCLES =
    int'(SECOND_NS / CLK_PERIOD_NS);
  localparam int unsigned     HOUR_SECONDS  = 3600;

  // ********************************************************************
  // Decoders
  // ********************************************************************
  function automatic logic mode_is_auto(input logic [2:0] m);
    return m[2];
  endfunction : mode_is_auto

  function automatic logic mode_runs_timed(input logic [2:0] m);
    return m[2] | (m == MODE_EMERG);
  endfunction : mode_runs_timed

  function automatic logic [1:0] mode_unit(input logic [2:0] m);
    if (m == MODE_OFF) return UNIT_NONE;
    if (m == MODE_EMERG) return UNIT_HOUR;
    return m[0] ? UNIT_MIN : UNIT_SEC;
  endfunction : mode_unit

endpackage : cbac_pkg

// *** logic/cbac_notice_timer.sv ***
`timescale 1ns/10ps
module cbac_notice_timer #(
  parameter int unsigned P_SEC_CYCLES = cbac_pkg::SECOND_CYCLES,
  parameter int unsigned P_HOUR_SECS  = cbac_pkg::HOUR_SECONDS
) (
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_ce,
  input  wire logic       i_enable,
  input  wire logic [1:0] i_interval,
  output logic            o_alert
);
  typedef struct packed {
    logic [31:0] tick;
    logic [31:0] secs;
    logic        alert;
  } cbac_nt_state_t;

  cbac_nt_state_t s_r;
  cbac_nt_state_t s_nxt;
  logic [31:0]    limit;

  // Interval code 1,2,3 means 1,2,4 hours, counted only in cycles with i_ce high
  always_comb begin
    limit = '0;
    if (i_interval != 2'h0) begin
      limit = P_HOUR_SECS << (i_interval - 2'h1);
    end
    s_nxt = s_r;
    s_nxt.alert = 1'b0;
    if (!i_enable || (i_interval == 2'h0)) begin
      s_nxt.tick = '0;
      s_nxt.secs = '0;
    end else if (s_r.tick == P_SEC_CYCLES - 1) begin
      s_nxt.tick = '0;
      // Compare with >= so a shorter interval written mid-count cannot
      // leave the counter above its limit until it wraps
      if (s_r.secs >= limit - 32'h0000_0001) begin
        s_nxt.secs  = '0;
        s_nxt.alert = 1'b1;
      end else begin
        s_nxt.secs = s_r.secs + 32'h0000_0001;
      end
    end else begin
      s_nxt.tick = s_r.tick + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      s_r <= '0;
    end else if (i_ce) begin
      s_r <= s_nxt;
    end
  end

  assign o_alert = s_r.alert;

endmodule : cbac_notice_timer

// *** logic/cbac_cal_sched.sv ***
`timescale 1ns/10ps
module cbac_cal_sched (
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_ce,
  input  wire logic       i_pair_done,
  input  wire logic [1:0] i_meas_enable,
  input  wire logic [2:0] i_rate,
  output logic            o_meas_req,
  output logic            o_cal_req
);
  typedef enum logic [2:0] {
    CS_IDLE = 3'b001,
    CS_MEAS = 3'b010,
    CS_CAL  = 3'b100
  } cbac_cs_t;

  typedef struct packed {
    cbac_cs_t   st;
    logic [5:0] cnt;
  } cbac_cs_state_t;

  cbac_cs_state_t s_r;
  cbac_cs_state_t s_nxt;
  logic [5:0]     period;

  always_comb begin
    unique case (i_rate)
      3'h1:    period = 6'h02;
      3'h2:    period = 6'h04;
      3'h3:    period = 6'h08;
      3'h4:    period = 6'h0c;
      3'h5:    period = 6'h10;
      3'h6,
      3'h7:    period = 6'h20;
      default: period = 6'h00;
    endcase
    s_nxt = s_r;
    s_nxt.st = CS_IDLE;
    // Upper enable bit clear: no measurement and rate is ignored
    if (i_pair_done && i_meas_enable[1]) begin
      if ((period != 6'h00) && (s_r.cnt + 6'h01 >= period)) begin
        s_nxt.st  = CS_CAL;
        s_nxt.cnt = '0;
      end else begin
        s_nxt.st  = CS_MEAS;
        s_nxt.cnt = (period == 6'h00) ? 6'h00 : s_r.cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      s_r <= '{st: CS_IDLE, cnt: 6'h00};
    end else if (i_ce) begin
      s_r <= s_nxt;
    end
  end

  // One-hot state bits drive the request pins with no decode in between
  assign o_meas_req = s_r.st[1];
  assign o_cal_req  = s_r.st[2];

endmodule : cbac_cal_sched

// *** logic/cbac_top.sv ***
`timescale 1ns/10ps
module cbac_top #(
  parameter int unsigned P_SEC_CYCLES = cbac_pkg::SECOND_CYCLES,
  parameter int unsigned P_HOUR_SECS  = cbac_pkg::HOUR_SECONDS
) (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_ce,
  input  wire logic [7:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  input  wire logic [2:0]  i_balancing_mode_select,
  input  wire logic        i_balancing_running,
  input  wire logic        i_shutdown_pin_hold,
  input  wire logic        i_scan_active,
  input  wire logic [3:0]  i_lowest_cell_index,
  input  wire logic        i_extremes_polarity_select,
  input  wire logic [195:0] i_cell_result_register,
  input  wire logic [1:0]  i_supervisory_measure_enable,
  input  wire logic        i_pair_done,
  input  wire logic        i_measure_done,
  output logic      [9:0]  o_cell14_expiry_time,
  output logic      [1:0]  o_expiry_unit,
  output logic             o_cell14_expired,
  output logic             o_cell14_indefinite,
  output logic      [13:0] o_balance_uv_threshold,
  output logic             o_threshold_from_lowest_cell,
  output logic      [13:0] o_cell_suspend,
  output logic             o_write_reject_alert,
  output logic             o_progress_notice_alert,
  output logic             o_supervisory_measure_req,
  output logic             o_calibration_req
);

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    logic [15:0] rdata;
    logic [9:0]  expiry;
    logic        expired;
    logic        indefinite;
    logic [1:0]  unit;
    logic [13:0] thr;
    logic        thr_sel;
    logic [1:0]  ntfy;
    logic [2:0]  cal_rate;
    logic        reject;
    logic [13:0] suspend;
  } cbac_top_state_t;

  cbac_top_state_t s_r;
  cbac_top_state_t s_nxt;
  logic            auto_mode;
  logic            timing_lock;
  logic            notice_en;
  logic [13:0]     lowest_val;

  function automatic logic [13:0] pick_cell(
    input logic [195:0] all,
    input logic [3:0]   idx
  );
    if (idx >= 4'(cbac_pkg::CELL_N)) return cbac_pkg::THR_ALL_ONES;
    return all[idx*cbac_pkg::THR_W +: cbac_pkg::THR_W];
  endfunction : pick_cell

  // ********************************************************************
  // Register decode
  // ********************************************************************
  always_comb begin
    auto_mode   = cbac_pkg::mode_is_auto(i_balancing_mode_select);
    timing_lock = cbac_pkg::mode_runs_timed(i_balancing_mode_select);
    lowest_val  = pick_cell(i_cell_result_register, i_lowest_cell_index);
    s_nxt        = s_r;
    s_nxt.reject = 1'b0;
    if (i_wr) begin
      case (i_addr)
        cbac_pkg::OFS_EXPIRY: begin
          if (!auto_mode) begin
            s_nxt.expiry = i_wdata[cbac_pkg::EXP_LSB +: cbac_pkg::EXP_W];
          end
        end
        cbac_pkg::OFS_THR: begin
          if (auto_mode) begin
            s_nxt.reject = 1'b0;
          end else if (i_wdata[cbac_pkg::SEL_BIT] && i_scan_active) begin
            s_nxt.reject = 1'b1;
          end else if (i_wdata[cbac_pkg::SEL_BIT]) begin
            s_nxt.thr_sel = 1'b1;
            s_nxt.thr = i_extremes_polarity_select ?
                        cbac_pkg::THR_ALL_ONES : lowest_val;
          end else begin
            s_nxt.thr_sel = 1'b0;
            s_nxt.thr = i_wdata[cbac_pkg::THR_LSB +: cbac_pkg::THR_W];
          end
        end
        cbac_pkg::OFS_TIMING: begin
          if (!timing_lock) begin
            s_nxt.ntfy     = i_wdata[cbac_pkg::NTFY_LSB +: 2];
            s_nxt.cal_rate = i_wdata[cbac_pkg::CAL_LSB +: 3];
          end
        end
        default: s_nxt.reject = 1'b0;
      endcase
    end
    // Read data stand only in the cycle after the strobe
    s_nxt.rdata = 16'h0000;
    if (i_rd) begin
      case (i_addr)
        cbac_pkg::OFS_EXPIRY: s_nxt.rdata = {6'h00, s_r.expiry};
        cbac_pkg::OFS_THR:
          s_nxt.rdata = {s_r.thr, 1'b0, s_r.thr_sel};
        cbac_pkg::OFS_TIMING:
          s_nxt.rdata = {6'h00, s_r.ntfy, 5'h00, s_r.cal_rate};
        default: s_nxt.rdata = 16'h0000;
      endcase
    end
    s_nxt.expired    = (s_nxt.expiry == cbac_pkg::EXP_RESET);
    s_nxt.indefinite = (s_nxt.expiry == cbac_pkg::EXP_FOREVER);
    s_nxt.unit = cbac_pkg::mode_unit(i_balancing_mode_select);
    // Undervoltage compare on each supervisory result outside MODE_OFF, which clears all suspend bits
    if (i_balancing_mode_select == cbac_pkg::MODE_OFF) begin
      s_nxt.suspend = '0;
    end else if (i_measure_done && i_supervisory_measure_enable[1]) begin
      for (int c = 0; c < cbac_pkg::CELL_N; c++) begin
        s_nxt.suspend[c] =
          i_cell_result_register[c*cbac_pkg::THR_W +: cbac_pkg::THR_W]
          < s_r.thr;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      s_r            <= '0;
      s_r.expiry     <= cbac_pkg::EXP_RESET;
      s_r.expired    <= 1'b1;
      s_r.thr        <= cbac_pkg::THR_ALL_ONES;
      s_r.ntfy       <= cbac_pkg::NTFY_RESET;
      s_r.cal_rate   <= cbac_pkg::CAL_RESET;
    end else if (i_ce) begin
      s_r <= s_nxt;
    end
  end

  // ********************************************************************
  // Progress notice and supervisory scheduling
  // ********************************************************************
  // Counts only cycles with i_ce high while enabled; any drop of the enable restarts the count
  always_comb begin
    notice_en = (timing_lock && i_balancing_running)
              || i_shutdown_pin_hold;
  end

  cbac_notice_timer #(
    .P_SEC_CYCLES (P_SEC_CYCLES),
    .P_HOUR_SECS  (P_HOUR_SECS)
  ) u_notice (
    .i_clk      (i_clk),
    .i_reset    (i_reset),
    .i_ce       (i_ce),
    .i_enable   (notice_en),
    .i_interval (s_r.ntfy),
    .o_alert    (o_progress_notice_alert)
  );

  cbac_cal_sched u_cal (
    .i_clk         (i_clk),
    .i_reset       (i_reset),
    .i_ce          (i_ce),
    .i_pair_done   (i_pair_done && timing_lock),
    .i_meas_enable (i_supervisory_measure_enable),
    .i_rate        (s_r.cal_rate),
    .o_meas_req    (o_supervisory_measure_req),
    .o_cal_req     (o_calibration_req)
  );

  assign o_rdata                      = s_r.rdata;
  assign o_cell14_expiry_time         = s_r.expiry;
  assign o_expiry_unit                = s_r.unit;
  assign o_cell14_expired             = s_r.expired;
  assign o_cell14_indefinite          = s_r.indefinite;
  assign o_balance_uv_threshold       = s_r.thr;
  assign o_threshold_from_lowest_cell = s_r.thr_sel;
  assign o_cell_suspend               = s_r.suspend;
  assign o_write_reject_alert         = s_r.reject;

  // ********************************************************************
  // Assertions
  // ********************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  property p_exp_load;
    (i_ce && i_wr && i_addr == cbac_pkg::OFS_EXPIRY
      && !i_balancing_mode_select[2])
    |=> o_cell14_expiry_time == $past(i_wdata[9:0]);
  endproperty
  a_exp_load: assert property (p_exp_load)
    else $error("expiry write not stored");

  property p_indef;
    o_cell14_indefinite == (o_cell14_expiry_time == 10'h3ff)
      && !(o_cell14_indefinite && o_cell14_expired);
  endproperty
  a_indef: assert property (p_indef)
    else $error("indefinite flag wrong");

  property p_expired;
    o_cell14_expired == (o_cell14_expiry_time == 10'h000);
  endproperty
  a_expired: assert property (p_expired)
    else $error("expired flag wrong");

  property p_auto_block;
    (i_ce && i_wr && i_balancing_mode_select[2]
      && (i_addr == cbac_pkg::OFS_EXPIRY || i_addr == cbac_pkg::OFS_THR))
    |=> $stable(o_cell14_expiry_time) && $stable(o_balance_uv_threshold)
        && !o_write_reject_alert;
  endproperty
  a_auto_block: assert property (p_auto_block)
    else $error("write taken in automated mode");

  property p_timing_block;
    (i_ce && i_wr && i_addr == cbac_pkg::OFS_TIMING
      && (i_balancing_mode_select[2] || i_balancing_mode_select == 3'h1))
    |=> $stable(s_r.ntfy) && $stable(s_r.cal_rate);
  endproperty
  a_timing_block: assert property (p_timing_block)
    else $error("timing write not blocked");

  property p_reject;
    (i_ce && i_wr && i_addr == cbac_pkg::OFS_THR && i_wdata[0]
      && i_scan_active && !i_balancing_mode_select[2])
    |=> o_write_reject_alert && $stable(o_balance_uv_threshold)
        ##1 !o_write_reject_alert || $past(i_wr);
  endproperty
  a_reject: assert property (p_reject)
    else $error("scan write not rejected");

  property p_thr_read;
    (i_ce && i_rd && i_addr == cbac_pkg::OFS_THR)
    |=> o_rdata == {$past(o_balance_uv_threshold), 1'b0,
                    $past(o_threshold_from_lowest_cell)};
  endproperty
  a_thr_read: assert property (p_thr_read)
    else $error("threshold readback wrong");

  property p_direct;
    (i_ce && i_wr && i_addr == cbac_pkg::OFS_THR && !i_wdata[0]
      && !i_balancing_mode_select[2])
    |=> o_balance_uv_threshold == $past(i_wdata[15:2])
        && !o_threshold_from_lowest_cell;
  endproperty
  a_direct: assert property (p_direct)
    else $error("direct threshold not loaded");

  property p_bipolar;
    (i_ce && i_wr && i_addr == cbac_pkg::OFS_THR && i_wdata[0]
      && !i_scan_active && !i_balancing_mode_select[2]
      && i_extremes_polarity_select)
    |=> o_balance_uv_threshold == 14'h3fff;
  endproperty
  a_bipolar: assert property (p_bipolar)
    else $error("bipolar select not forced to ones");

  property p_cal_off;
    (o_calibration_req || o_supervisory_measure_req) && $past(i_ce)
    |-> $past(i_supervisory_measure_enable[1]) && $past(i_pair_done);
  endproperty
  a_cal_off: assert property (p_cal_off)
    else $error("request without enable or pair");

  property p_unused;
    (i_ce && i_rd && i_addr == cbac_pkg::OFS_TIMING)
    |=> o_rdata[15:10] == 6'h00 && o_rdata[7:3] == 5'h00
        ##1 o_rdata == 16'h0000 || $past(i_rd);
  endproperty
  a_unused: assert property (p_unused)
    else $error("unused bits not zero");

  c_reject: cover property (o_write_reject_alert);
  c_lowest: cover property (i_ce && i_wr && i_addr == cbac_pkg::OFS_THR
    && i_wdata[0] && !i_scan_active && !i_balancing_mode_select[2]);
  c_notice: cover property (o_progress_notice_alert);
  c_cal:    cover property (o_calibration_req);

endmodule : cbac_top

// *** bench/cell_balance_auto_config_tb.sv ***
`timescale 1ns/10ps
module cell_balance_auto_config_tb;
  // ********************************************************************
  // Bench signals
  // ********************************************************************
  localparam int unsigned LIMIT = 30000;
  logic         clk      = 1'b0;
  logic         rst      = 1'b1;
  logic         ce       = 1'b1;
  logic [7:0]   addr     = 8'h00;
  logic [15:0]  wdata    = 16'h0000;
  logic         wr       = 1'b0;
  logic         rd       = 1'b0;
  logic [2:0]   mode     = 3'h0;
  logic         running  = 1'b0;
  logic         hold     = 1'b0;
  logic         scan     = 1'b0;
  logic [3:0]   low_idx  = 4'h3;
  logic         pol      = 1'b0;
  logic [195:0] cells;
  logic [1:0]   meas_en  = 2'h0;
  logic         pair     = 1'b0;
  logic         mdone    = 1'b0;
  logic [15:0]  rdata;
  logic [9:0]   exp_t;
  logic [1:0]   unit;
  logic         expired;
  logic         forever_on;
  logic [13:0]  thr;
  logic         from_low;
  logic [13:0]  suspend;
  logic         reject;
  logic         notice;
  logic         meas;
  logic         cal;
  int           miscompares = 0;
  int           checks_done = 0;
  int           cycles      = 0;
  int           per[8]      = '{4, 2, 4, 8, 12, 16, 32, 32};

  initial begin
    forever #50 clk = ~clk;
  end

  initial begin
    for (int c = 0; c < 14; c++) begin
      cells[14*c +: 14] = 14'(c * 64 + 5);
    end
  end

  cbac_top #(.P_SEC_CYCLES(2), .P_HOUR_SECS(2)) dut_u (
    .i_clk(clk), .i_reset(rst), .i_ce(ce), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_balancing_mode_select(mode), .i_balancing_running(running),
    .i_shutdown_pin_hold(hold), .i_scan_active(scan),
    .i_lowest_cell_index(low_idx), .i_extremes_polarity_select(pol),
    .i_cell_result_register(cells), .i_supervisory_measure_enable(meas_en),
    .i_pair_done(pair), .i_measure_done(mdone),
    .o_cell14_expiry_time(exp_t), .o_expiry_unit(unit),
    .o_cell14_expired(expired), .o_cell14_indefinite(forever_on),
    .o_balance_uv_threshold(thr), .o_threshold_from_lowest_cell(from_low),
    .o_cell_suspend(suspend), .o_write_reject_alert(reject),
    .o_progress_notice_alert(notice), .o_supervisory_measure_req(meas),
    .o_calibration_req(cal));

  // ********************************************************************
  // Tasks
  // ********************************************************************
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] expd);
    checks_done++;
    if (seen !== expd) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, expd, seen);
    end
  endtask : check

  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
  endtask : do_reset

  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : reg_wr

  task automatic reg_chk(input logic [7:0] a, input logic [15:0] expd);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check("rdata", rdata, expd);
  endtask : reg_chk

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  // Pulses one pair end and counts requests over the following cycles
  task automatic pair_chk(input logic exp_cal, input logic exp_meas);
    int nc;
    int nm;
    nc = 0;
    nm = 0;
    @(posedge clk);
    pair <= 1'b1;
    @(posedge clk);
    pair <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      #1;
      nc += (cal === 1'b1);
      nm += (meas === 1'b1);
      @(posedge clk);
    end
    check("cal req", 16'(nc), 16'(exp_cal));
    check("meas req", 16'(nm), 16'(exp_meas));
  endtask : pair_chk

  // Measures the spacing of two notice pulses in clock cycles
  task automatic notice_gap(input int expd);
    int n;
    n = 0;
    while (notice !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (notice !== 1'b1 && n < 200);
    check("notice gap", 16'(n), 16'(expd));
  endtask : notice_gap

  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      summarize();
    end
  end

  // ********************************************************************
  // Test sequence
  // ********************************************************************
  initial begin
    int n;
    do_reset();
    reg_chk(8'h7d, 16'h0000);
    reg_chk(8'h7e, 16'hfffc);
    reg_chk(8'h7f, 16'h0000);
    check("expired", 16'(expired), 16'h0001);
    check("thr", 16'(thr), 16'h3fff);
    reg_chk(8'h10, 16'h0000);
    reg_wr(8'h7d, 16'hffff);
    settle();
    reg_chk(8'h7d, 16'h03ff);
    check("expiry", 16'(exp_t), 16'h03ff);
    check("indefinite", 16'(forever_on), 16'h0001);
    check("expired", 16'(expired), 16'h0000);
    reg_wr(8'h7d, 16'h0000);
    settle();
    check("expired", 16'(expired), 16'h0001);
    ce <= 1'b0;
    reg_wr(8'h7d, 16'h0155);
    check("frozen expiry", 16'(exp_t), 16'h0000);
    ce <= 1'b1;
    reg_wr(8'h7f, 16'hffff);
    reg_chk(8'h7f, 16'h0307);
    reg_wr(8'h7e, 16'h0010);
    reg_chk(8'h7e, 16'h0010);
    check("thr", 16'(thr), 16'h0004);
    reg_wr(8'h7e, 16'hffff);
    reg_chk(8'h7e, 16'h0315);
    check("from lowest", 16'(from_low), 16'h0001);
    pol <= 1'b1;
    reg_wr(8'h7e, 16'h0001);
    reg_chk(8'h7e, 16'hfffd);
    pol  <= 1'b0;
    scan <= 1'b1;
    reg_wr(8'h7e, 16'h0011);
    check("reject", 16'(reject), 16'h0001);
    @(posedge clk);
    #1;
    check("reject", 16'(reject), 16'h0000);
    scan <= 1'b0;
    reg_chk(8'h7e, 16'hfffd);
    for (int m = 0; m < 8; m++) begin
      mode <= 3'(m);
      settle();
      check("unit", 16'(unit), (m == 0) ? 16'h0000 : (m == 1) ? 16'h0003 :
            (m % 2 == 1) ? 16'h0002 : 16'h0001);
    end
    mode <= 3'h4;
    reg_wr(8'h7d, 16'h0155);
    reg_chk(8'h7d, 16'h0000);
    reg_wr(8'h7e, 16'h0040);
    reg_chk(8'h7e, 16'hfffd);
    reg_wr(8'h7f, 16'h0000);
    reg_chk(8'h7f, 16'h0307);
    mode <= 3'h1;
    reg_wr(8'h7f, 16'h0000);
    reg_chk(8'h7f, 16'h0307);
    reg_wr(8'h7d, 16'h0155);
    reg_chk(8'h7d, 16'h0155);
    mode <= 3'h0;
    reg_wr(8'h7e, 16'h0400);
    mode    <= 3'h1;
    meas_en <= 2'h2;
    @(posedge clk);
    mdone <= 1'b1;
    @(posedge clk);
    mdone <= 1'b0;
    settle();
    check("suspend", 16'(suspend), 16'h000f);
    for (int k = 0; k < 8; k++) begin
      mode    <= 3'h0;
      meas_en <= 2'h2;
      do_reset();
      reg_wr(8'h7f, 16'(k));
      mode <= 3'h1;
      for (int p = 1; p <= per[k]; p++) begin
        pair_chk(k != 0 && p == per[k], k == 0 || p != per[k]);
      end
      pair_chk(1'b0, 1'b1);
      meas_en <= 2'h1;
      pair_chk(1'b0, 1'b0);
    end
    meas_en <= 2'h0;
    for (int k = 1; k < 4; k++) begin
      mode    <= 3'h0;
      running <= 1'b0;
      do_reset();
      reg_wr(8'h7f, 16'(k) << 8);
      mode    <= 3'h1;
      running <= 1'b1;
      notice_gap(4 << (k - 1));
    end
    mode    <= 3'h0;
    running <= 1'b0;
    hold    <= 1'b1;
    notice_gap(16);
    hold <= 1'b0;
    reg_wr(8'h7f, 16'h0000);
    mode    <= 3'h4;
    running <= 1'b1;
    n = 0;
    repeat (40) begin
      @(posedge clk);
      #1;
      n += (notice !== 1'b0);
    end
    check("notice off", 16'(n), 16'h0000);
    summarize();
  end
endmodule : cell_balance_auto_config_tb
